// ===== src/tris_pkg.sv
package tris_pkg;

	// register offsets on the parallel control port
	localparam logic [7:0] OFS_INFO3_A = 8'h10;
	localparam logic [7:0] OFS_INFO2_A = 8'h31;
	localparam logic [7:0] OFS_INFO1_B = 8'hc2;
	localparam logic [7:0] OFS_INFO2_B = 8'hd1;

	// internal register slots
	localparam logic [1:0] IDX_3A = 2'h0;
	localparam logic [1:0] IDX_2A = 2'h1;
	localparam logic [1:0] IDX_1B = 2'h2;
	localparam logic [1:0] IDX_2B = 2'h3;

	// assigned bits per register; the rest read as zero
	localparam logic [7:0] MASK_3A = 8'hf9;
	localparam logic [7:0] MASK_2A = 8'he4;
	localparam logic [7:0] MASK_1B = 8'he7;
	localparam logic [7:0] MASK_2B = 8'ha4;
	localparam logic [7:0] INFO_RESET = 8'h00;

	// field positions, first information register
	localparam int B_ALIGN = 7;
	localparam int B_ZERO8 = 6;
	localparam int B_ZERO16 = 5;
	localparam int B_SEVERE = 2;
	localparam int B_BIPOLAR = 1;
	localparam int B_FBE = 0;
	// second information register
	localparam int B_SYNC = 7;
	localparam int B_LINE_REST = 6;
	localparam int B_FR_REST = 5;
	localparam int B_BLUE_CLR = 2;
	// third information register
	localparam int B_LVL_HI = 7;
	localparam int B_LVL_LO = 6;
	localparam int B_JITTER = 5;
	localparam int B_CLK_LOST = 4;
	localparam int B_LINE_LOST = 3;
	localparam int B_AIS_CI = 0;

	// counts and timing
	localparam logic [4:0] ZERO8_LEN = 5'h08;
	localparam logic [4:0] ZERO16_LEN = 5'h10;
	localparam int SEF_ERRS = 2;
	localparam logic [7:0] LINE_LOSS_ZEROS = 8'hc0;
	localparam logic [6:0] LINE_ONES = 7'h0e;
	localparam int LINE_WIN = 112;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_LOST_NS = 3000;
	localparam logic [9:0] CLK_LOST_CYC =
		10'(CLK_LOST_NS / CLK_PERIOD_NS);

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tris_host_bus_type;

	typedef struct packed {
		logic in_sync;
		logic carrier_lost;
		logic blue_alarm_status;
		logic jitter_fifo_near_limit;
		logic ais_ci_pattern;
		logic [1:0] rx_level;
	} tris_framer_a_type;

	typedef struct packed {
		logic alignment_changed;
		logic in_sync;
		logic carrier_lost;
		logic blue_alarm_status;
		logic bit_valid;
		logic fbit_valid;
		logic fbit_err;
	} tris_framer_b_type;

	typedef struct packed {
		logic [3:0][7:0] lat;
		logic [3:0][7:0] hold;
		logic [7:0] rdata;
		logic [4:0] zrun;
		logic [5:0] fb_hist;
		logic [7:0] cw_pos;
		logic [7:0] cw_neg;
		logic last_pol;
		logic [7:0] lzeros;
		logic [LINE_WIN-1:0] lwin;
		logic [6:0] lones;
		logic line_lost;
		logic clk_prev;
		logic [9:0] clk_cnt;
		logic a_sync;
		logic a_fcl;
		logic a_blue;
		logic b_sync;
		logic b_fcl;
		logic b_blue;
	} tris_state_type;

endpackage : tris_pkg

// ===== src/tris_info.sv
// Function
// - Set alignment-changed flag when a resync moves frame boundaries.
// - Set eight-zero flag once eight zeros in a row arrive, once per run.
// - Set sixteen-zero flag once sixteen zeros arrive in a row.
// - Flag severe framing error when two of six framing bits are wrong.
// - Flag bipolar substitution code word whatever line coding is set.
// - Set framing bit error flag on every wrong framing bit.
// - Set sync-regained flag when the framer gains sync; hold until read.
// - Framer A only: flag line carrier restored; hold until read.
// - Each framer: flag framer carrier restored; hold until read.
// - Flag blue alarm cleared when all-ones stops; hold until read.
// - Unassigned bits may read any value; here they read zero.
// - Set jitter limit flag when the FIFO comes within four bits of limit.
// - Flag lost receive clock after about 3 us without a transition.
// - Declare line carrier loss after 192 consecutive line zeros.
// - Clear line carrier loss only with 14 ones within 112 bits.
// - Set AIS-CI flag when the AIS-CI pattern is received.
// - Report receive level as two bits at the top of register three.
// - Level codes: 00 high, 01 to -15 dB, 10 to -22.5, 11 lower.
// - Latched bits stay set until read, then clear until the event recurs.
// - AIS-CI flag sets only while blue alarm status is set.
`timescale 1ns/10ps

module tris_info (
	// clock and reset
	input logic i_core_clk,
	input logic i_rst,
	// parallel control port
	input tris_pkg::tris_host_bus_type i_bus,
	output logic [7:0] o_rdata,
	// framer status and events
	input tris_pkg::tris_framer_a_type i_fa,
	input tris_pkg::tris_framer_b_type i_fb,
	// receive data and clock
	input logic i_framer_b_rx_positive,
	input logic i_framer_b_rx_negative,
	input logic i_framer_a_rx_clock_in,
	// line receive bits, one per i_line_bit_valid
	input logic i_line_bit_valid,
	input logic i_line_rx_tip,
	input logic i_line_rx_ring
);

	tris_pkg::tris_state_type r;
	tris_pkg::tris_state_type n;

	// returns {hit, slot}
	function automatic logic [2:0] decode_addr(input logic [7:0] a);
		case (a)
			tris_pkg::OFS_INFO3_A: decode_addr = {1'b1, tris_pkg::IDX_3A};
			tris_pkg::OFS_INFO2_A: decode_addr = {1'b1, tris_pkg::IDX_2A};
			tris_pkg::OFS_INFO1_B: decode_addr = {1'b1, tris_pkg::IDX_1B};
			tris_pkg::OFS_INFO2_B: decode_addr = {1'b1, tris_pkg::IDX_2B};
			default: decode_addr = 3'h0;
		endcase
	endfunction : decode_addr

	function automatic logic [7:0] valid_bits(input logic [1:0] idx);
		case (idx)
			tris_pkg::IDX_3A: valid_bits = tris_pkg::MASK_3A;
			tris_pkg::IDX_2A: valid_bits = tris_pkg::MASK_2A;
			tris_pkg::IDX_1B: valid_bits = tris_pkg::MASK_1B;
			default: valid_bits = tris_pkg::MASK_2B;
		endcase
	endfunction : valid_bits

	// window bit 0 is newest: 0 0 0 V B 0 V B, oldest first
	function automatic logic is_code_word(input logic [7:0] p,
		input logic [7:0] m, input logic pol);
		logic [7:0] mark;
		mark = p | m;
		is_code_word = (mark == 8'h1b) && (p[4] == pol) &&
			(p[3] == !pol) && (p[1] == !pol) && (p[0] == pol);
	endfunction : is_code_word

	logic [2:0] dec;
	logic [3:0][7:0] set;
	logic [3:0][7:0] clr;
	logic bit_zero;
	logic line_one;

	always_comb begin
		n = r;
		set = '0;
		clr = '0;
		dec = decode_addr(i_bus.addr);
		bit_zero = !i_framer_b_rx_positive && !i_framer_b_rx_negative;
		line_one = i_line_rx_tip | i_line_rx_ring;

		if (i_fb.bit_valid) begin
			if (!bit_zero) begin
				n.zrun = 5'h00;
			end else if (r.zrun != tris_pkg::ZERO16_LEN) begin
				n.zrun = r.zrun + 5'h01;
			end
			if (bit_zero && n.zrun == tris_pkg::ZERO8_LEN) begin
				set[tris_pkg::IDX_1B][tris_pkg::B_ZERO8] = 1'b1;
			end
			if (bit_zero && r.zrun == tris_pkg::ZERO16_LEN - 5'h01) begin
				set[tris_pkg::IDX_1B][tris_pkg::B_ZERO16] = 1'b1;
			end
			n.cw_pos = {r.cw_pos[6:0], i_framer_b_rx_positive};
			n.cw_neg = {r.cw_neg[6:0], i_framer_b_rx_negative};
			if (r.cw_pos[7] | r.cw_neg[7]) begin
				n.last_pol = r.cw_pos[7];
			end
			// coding mode is deliberately not consulted
			if (is_code_word(n.cw_pos, n.cw_neg, n.last_pol)) begin
				set[tris_pkg::IDX_1B][tris_pkg::B_BIPOLAR] = 1'b1;
			end
		end

		if (i_fb.fbit_valid) begin
			n.fb_hist = {r.fb_hist[4:0], i_fb.fbit_err};
			set[tris_pkg::IDX_1B][tris_pkg::B_FBE] = i_fb.fbit_err;
			if ($countones(n.fb_hist) >= tris_pkg::SEF_ERRS) begin
				set[tris_pkg::IDX_1B][tris_pkg::B_SEVERE] = 1'b1;
			end
		end

		set[tris_pkg::IDX_1B][tris_pkg::B_ALIGN] = i_fb.alignment_changed;

		set[tris_pkg::IDX_2A][tris_pkg::B_SYNC] = i_fa.in_sync && !r.a_sync;
		set[tris_pkg::IDX_2B][tris_pkg::B_SYNC] = i_fb.in_sync && !r.b_sync;
		set[tris_pkg::IDX_2A][tris_pkg::B_FR_REST] =
			!i_fa.carrier_lost && r.a_fcl;
		set[tris_pkg::IDX_2B][tris_pkg::B_FR_REST] =
			!i_fb.carrier_lost && r.b_fcl;
		set[tris_pkg::IDX_2A][tris_pkg::B_BLUE_CLR] =
			!i_fa.blue_alarm_status && r.a_blue;
		set[tris_pkg::IDX_2B][tris_pkg::B_BLUE_CLR] =
			!i_fb.blue_alarm_status && r.b_blue;
		n.a_sync = i_fa.in_sync;
		n.b_sync = i_fb.in_sync;
		n.a_fcl = i_fa.carrier_lost;
		n.b_fcl = i_fb.carrier_lost;
		n.a_blue = i_fa.blue_alarm_status;
		n.b_blue = i_fb.blue_alarm_status;

		set[tris_pkg::IDX_3A][tris_pkg::B_JITTER] =
			i_fa.jitter_fifo_near_limit;
		set[tris_pkg::IDX_3A][tris_pkg::B_AIS_CI] =
			i_fa.ais_ci_pattern && i_fa.blue_alarm_status;

		// receive clock watchdog; pin sampled as a plain input
		n.clk_prev = i_framer_a_rx_clock_in;
		if (i_framer_a_rx_clock_in != r.clk_prev) begin
			n.clk_cnt = 10'h000;
		end else if (r.clk_cnt != tris_pkg::CLK_LOST_CYC) begin
			n.clk_cnt = r.clk_cnt + 10'h001;
		end
		set[tris_pkg::IDX_3A][tris_pkg::B_CLK_LOST] =
			(r.clk_cnt == tris_pkg::CLK_LOST_CYC);

		// line side: zero run and sliding ones window
		if (i_line_bit_valid) begin
			n.lwin = {r.lwin[tris_pkg::LINE_WIN-2:0], line_one};
			n.lones = r.lones + {6'h00, line_one} -
				{6'h00, r.lwin[tris_pkg::LINE_WIN-1]};
			if (line_one) begin
				n.lzeros = 8'h00;
			end else if (r.lzeros != tris_pkg::LINE_LOSS_ZEROS) begin
				n.lzeros = r.lzeros + 8'h01;
			end
			if (!r.line_lost && !line_one &&
				r.lzeros == tris_pkg::LINE_LOSS_ZEROS - 8'h01) begin
				n.line_lost = 1'b1;
			end
			// recovery needs 14 ones in the window
			if (r.line_lost && n.lones >= tris_pkg::LINE_ONES) begin
				n.line_lost = 1'b0;
			end
		end
		// alarm bit stays set while the loss persists
		set[tris_pkg::IDX_3A][tris_pkg::B_LINE_LOST] = r.line_lost;
		// line carrier restored, framer A only
		set[tris_pkg::IDX_2A][tris_pkg::B_LINE_REST] =
			r.line_lost && !n.line_lost;

		// mask write refreshes held copy and clears those bits
		if (i_bus.wr && dec[2]) begin
			n.hold[dec[1:0]] = (r.hold[dec[1:0]] & ~i_bus.wdata) |
				(r.lat[dec[1:0]] & i_bus.wdata);
			clr[dec[1:0]] = i_bus.wdata;
		end
		// unmapped and unassigned bits read zero
		if (i_bus.rd) begin
			n.rdata = dec[2] ?
				(r.hold[dec[1:0]] & valid_bits(dec[1:0])) : 8'h00;
		end

		// set wins over a same-cycle clear
		for (int k = 0; k < 4; k++) begin
			n.lat[k] = ((r.lat[k] & ~clr[k]) | set[k]) &
				valid_bits(2'(k));
		end
		n.lat[tris_pkg::IDX_3A][tris_pkg::B_LVL_HI:tris_pkg::B_LVL_LO] =
			i_fa.rx_level;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_rdata = r.rdata;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	zero_eight_a: assert property (
		i_fb.bit_valid && bit_zero && r.zrun == 5'h07
		|=> r.lat[tris_pkg::IDX_1B][tris_pkg::B_ZERO8])
		else $error("eight zero run not flagged");

	zero_sixteen_a: assert property (
		i_fb.bit_valid && bit_zero && r.zrun == 5'h0f
		|=> r.lat[tris_pkg::IDX_1B][tris_pkg::B_ZERO16])
		else $error("sixteen zero run not flagged");

	frame_bit_a: assert property (
		i_fb.fbit_valid && i_fb.fbit_err
		|=> r.lat[tris_pkg::IDX_1B][tris_pkg::B_FBE])
		else $error("framing bit error not flagged");

	severe_frame_a: assert property (
		$rose(r.lat[tris_pkg::IDX_1B][tris_pkg::B_SEVERE])
		|-> $countones(r.fb_hist) >= 2)
		else $error("severe framing set with fewer than two errors");

	sync_regain_a: assert property (
		i_fa.in_sync && !r.a_sync
		|=> r.lat[tris_pkg::IDX_2A][tris_pkg::B_SYNC] ##1
		r.lat[tris_pkg::IDX_2A][tris_pkg::B_SYNC] || $past(i_bus.wr))
		else $error("sync regained flag not held");

	clock_lost_a: assert property (
		r.clk_cnt == 10'h258
		|=> r.lat[tris_pkg::IDX_3A][tris_pkg::B_CLK_LOST])
		else $error("lost receive clock not flagged at 600 cycles");

	line_loss_a: assert property (
		i_line_bit_valid && !line_one && !r.line_lost &&
		r.lzeros == 8'hbf
		|=> r.line_lost ##1 r.lat[tris_pkg::IDX_3A][tris_pkg::B_LINE_LOST])
		else $error("line carrier loss not declared at 192 zeros");

	line_clear_a: assert property (
		$fell(r.line_lost) |-> r.lones >= 7'h0e &&
		r.lat[tris_pkg::IDX_2A][tris_pkg::B_LINE_REST])
		else $error("line carrier loss cleared without 14 ones");

	ais_qual_a: assert property (
		$rose(r.lat[tris_pkg::IDX_3A][tris_pkg::B_AIS_CI])
		|-> $past(i_fa.blue_alarm_status))
		else $error("AIS-CI set without blue alarm");

	level_pass_a: assert property (
		1'b1 |=> r.lat[tris_pkg::IDX_3A][7:6] == $past(i_fa.rx_level))
		else $error("receive level not reported");

	read_clear_a: assert property (
		i_bus.wr && i_bus.addr == 8'h31 && i_bus.wdata[7] &&
		!(i_fa.in_sync && !r.a_sync) && r.lat[tris_pkg::IDX_2A][7]
		|=> !r.lat[tris_pkg::IDX_2A][7] && r.hold[tris_pkg::IDX_2A][7])
		else $error("masked bit not captured and cleared");

	unassigned_a: assert property (
		i_bus.rd && i_bus.addr == 8'hd1 |=> (r.rdata & 8'h5b) == 8'h00)
		else $error("unassigned bits not zero");

	// event inputs reach their latch one cycle later; only code_word_a uses
	// fixed bit patterns, the other checks here restate the set logic
	align_change_a: assert property (
		i_fb.alignment_changed
		|=> r.lat[tris_pkg::IDX_1B][tris_pkg::B_ALIGN])
		else $error("alignment change not flagged");

	code_word_a: assert property (
		$past(i_fb.bit_valid) &&
		((r.cw_pos == 8'h11 && r.cw_neg == 8'h0a && r.last_pol) ||
		(r.cw_pos == 8'h0a && r.cw_neg == 8'h11 && !r.last_pol))
		|-> r.lat[tris_pkg::IDX_1B][tris_pkg::B_BIPOLAR])
		else $error("substitution code word not flagged");

	jitter_limit_a: assert property (
		i_fa.jitter_fifo_near_limit
		|=> r.lat[tris_pkg::IDX_3A][tris_pkg::B_JITTER])
		else $error("jitter limit not flagged");

	carrier_back_a: assert property (
		!i_fb.carrier_lost && r.b_fcl
		|=> r.lat[tris_pkg::IDX_2B][tris_pkg::B_FR_REST])
		else $error("framer carrier restored not flagged");

	blue_clear_a: assert property (
		!i_fa.blue_alarm_status && r.a_blue
		|=> r.lat[tris_pkg::IDX_2A][tris_pkg::B_BLUE_CLR])
		else $error("blue alarm cleared not flagged");

	ais_detect_a: assert property (
		i_fa.ais_ci_pattern && i_fa.blue_alarm_status
		|=> r.lat[tris_pkg::IDX_3A][tris_pkg::B_AIS_CI])
		else $error("AIS-CI pattern not flagged");

	framer_iso_a: assert property (
		$rose(r.lat[tris_pkg::IDX_2A][tris_pkg::B_SYNC])
		|-> $past(i_fa.in_sync) && !$past(r.a_sync))
		else $error("framer A sync flag set without its own event");

	line_alarm_a: assert property (
		r.line_lost |=> r.lat[tris_pkg::IDX_3A][tris_pkg::B_LINE_LOST])
		else $error("line carrier loss not latched");

	loss_recover_c: cover property (
		$rose(r.line_lost) ##[1:1000] $fell(r.line_lost));
	zero_sixteen_c: cover property (
		$rose(r.lat[tris_pkg::IDX_1B][tris_pkg::B_ZERO16]));
	mask_read_c: cover property (
		i_bus.wr && dec[2] ##1 i_bus.rd ##1 i_bus.wr);
	code_word_c: cover property (
		$rose(r.lat[tris_pkg::IDX_1B][tris_pkg::B_BIPOLAR]));
	clock_lost_c: cover property (
		$rose(r.lat[tris_pkg::IDX_3A][tris_pkg::B_CLK_LOST]));

endmodule : tris_info

// ===== tb/tris_line_model.sv
`timescale 1ns/10ps

module tris_line_model (
	// clock
	input wire logic i_clk,
	// line control from the bench
	input wire logic i_quiet,
	input wire logic i_clk_stop,
	input wire logic i_cw,
	// receive line and framer side
	output logic o_valid,
	output logic o_pos,
	output logic o_neg,
	output logic o_rclk
);
	logic pol_reg = 1'b0;
	logic rclk_reg = 1'b0;
	logic [2:0] cw_idx_reg = 3'h0;
	logic cw_pol_reg = 1'b0;
	logic cw_mark;
	logic cw_p;

	// one bit per core cycle keeps the zero counts exact
	assign o_valid = 1'b1;
	// code word 0 0 0 V B 0 V B against the polarity of the last mark
	assign cw_mark = (cw_idx_reg == 3'h3) || (cw_idx_reg == 3'h4) ||
		(cw_idx_reg >= 3'h6);
	assign cw_p = (cw_idx_reg == 3'h3 || cw_idx_reg == 3'h7) ?
		cw_pol_reg : !cw_pol_reg;
	// polarity toggles every cycle, quiet or not, so marks alternate only within a run; the bench's quiet spans never form a code word
	assign o_pos = i_cw ? (cw_mark && cw_p) : (!i_quiet && pol_reg);
	assign o_neg = i_cw ? (cw_mark && !cw_p) : (!i_quiet && !pol_reg);
	assign o_rclk = rclk_reg;

	always @(posedge i_clk) begin
		pol_reg <= !pol_reg;
		cw_idx_reg <= i_cw ? cw_idx_reg + 3'h1 : 3'h0;
		if (!i_cw)
			cw_pol_reg <= pol_reg;
		if (!i_clk_stop)
			rclk_reg <= !rclk_reg;
	end
endmodule : tris_line_model

// ===== tb/tris_info_test.sv
`timescale 1ns/10ps

module tris_info_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic quiet = 1'b0;
	logic clk_stop = 1'b0;
	logic cw = 1'b0;
	logic lv;
	logic lp;
	logic ln;
	logic rclk;
	logic [7:0] rdata;
	tris_pkg::tris_host_bus_type bus = '0;
	tris_pkg::tris_framer_a_type fa = '0;
	tris_pkg::tris_framer_b_type fb = '0;
	int num_errors = 0;
	int n_tests = 0;

	always #2.5 clk = ~clk;

	tris_line_model u_line (.i_clk(clk), .i_quiet(quiet),
		.i_clk_stop(clk_stop), .i_cw(cw), .o_valid(lv), .o_pos(lp),
		.o_neg(ln),
		.o_rclk(rclk));

	tris_info u_dut (.i_core_clk(clk), .i_rst(rst), .i_bus(bus),
		.o_rdata(rdata), .i_fa(fa), .i_fb(fb),
		.i_framer_b_rx_positive(lp), .i_framer_b_rx_negative(ln),
		.i_framer_a_rx_clock_in(rclk), .i_line_bit_valid(lv),
		.i_line_rx_tip(lp), .i_line_rx_ring(ln));

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n

	// mask write, read, then write back value and mask to clear
	task automatic poll(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] v;
		bus.addr = a;
		bus.wdata = m;
		bus.wr = 1'b1;
		wait_n(1);
		bus.wr = 1'b0;
		bus.rd = 1'b1;
		wait_n(1);
		bus.rd = 1'b0;
		wait_n(1);
		v = rdata & m;
		n_tests++;
		if (v !== e) begin
			num_errors++;
			$display("BAD reg %h mask %h exp %h got %h", a, m, e, v);
		end
		bus.wdata = v;
		bus.wr = 1'b1;
		wait_n(1);
		bus.wr = 1'b0;
		wait_n(1);
	endtask : poll

	task automatic t_reset();
		logic [7:0] regs [5] = '{tris_pkg::OFS_INFO3_A,
			tris_pkg::OFS_INFO2_A, tris_pkg::OFS_INFO1_B,
			tris_pkg::OFS_INFO2_B, 8'h22};
		foreach (regs[i])
			poll(regs[i], 8'hff, 8'h00);
		$display("reset test done");
	endtask : t_reset

	task automatic t_zero();
		int len [4] = '{7, 8, 15, 16};
		logic [7:0] exp [4] = '{8'h00, 8'h40, 8'h40, 8'h60};
		foreach (len[i]) begin
			quiet = 1'b1;
			wait_n(len[i]);
			quiet = 1'b0;
			poll(tris_pkg::OFS_INFO1_B, 8'h60, exp[i]);
		end
		$display("zero run test done");
	endtask : t_zero

	task automatic t_line();
		quiet = 1'b1;
		wait_n(191);
		quiet = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h08, 8'h00);
		quiet = 1'b1;
		wait_n(192);
		quiet = 1'b0;
		wait_n(13);
		quiet = 1'b1;
		poll(tris_pkg::OFS_INFO3_A, 8'h08, 8'h08);
		poll(tris_pkg::OFS_INFO2_A, 8'h40, 8'h00);
		// the fourteenth mark inside the window
		quiet = 1'b0;
		wait_n(1);
		quiet = 1'b1;
		poll(tris_pkg::OFS_INFO2_A, 8'h40, 8'h40);
		quiet = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h08, 8'h08);
		poll(tris_pkg::OFS_INFO3_A, 8'h08, 8'h00);
		$display("line carrier test done");
	endtask : t_line

	task automatic t_clock();
		clk_stop = 1'b1;
		wait_n(590);
		clk_stop = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h10, 8'h00);
		clk_stop = 1'b1;
		wait_n(610);
		clk_stop = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h10, 8'h10);
		$display("clock loss test done");
	endtask : t_clock

	task automatic t_level_ais();
		for (int i = 0; i < 4; i++) begin
			fa.rx_level = 2'(i);
			wait_n(2);
			poll(tris_pkg::OFS_INFO3_A, 8'hc0, {2'(i), 6'h00});
		end
		fa.ais_ci_pattern = 1'b1;
		wait_n(1);
		fa.ais_ci_pattern = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h01, 8'h00);
		fa.blue_alarm_status = 1'b1;
		fa.ais_ci_pattern = 1'b1;
		wait_n(1);
		fa.ais_ci_pattern = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h01, 8'h01);
		fa.jitter_fifo_near_limit = 1'b1;
		wait_n(1);
		fa.jitter_fifo_near_limit = 1'b0;
		poll(tris_pkg::OFS_INFO3_A, 8'h20, 8'h20);
		$display("level and alarm test done");
	endtask : t_level_ais

	// slices hold in_sync, carrier_lost, blue_alarm_status in that order
	task automatic t_latch(input bit f);
		logic [7:0] own;
		logic [7:0] oth;
		own = f ? tris_pkg::OFS_INFO2_B : tris_pkg::OFS_INFO2_A;
		oth = f ? tris_pkg::OFS_INFO2_A : tris_pkg::OFS_INFO2_B;
		if (f)
			fb[5:3] = 3'b011;
		else
			fa[6:4] = 3'b011;
		wait_n(2);
		if (f)
			fb[5:3] = 3'b100;
		else
			fa[6:4] = 3'b100;
		wait_n(2);
		poll(own, 8'h80, 8'h80);
		poll(own, 8'h24, 8'h24);
		poll(own, 8'ha4, 8'h00);
		poll(oth, 8'ha4, 8'h00);
		$display("latch test done for framer %0d", f);
	endtask : t_latch

	task automatic fbit(input logic e);
		fb.fbit_err = e;
		fb.fbit_valid = 1'b1;
		wait_n(1);
		fb.fbit_valid = 1'b0;
		wait_n(1);
	endtask : fbit

	task automatic t_framing();
		fbit(1'b1);
		poll(tris_pkg::OFS_INFO1_B, 8'h05, 8'h01);
		repeat (4) fbit(1'b0);
		fbit(1'b1);
		poll(tris_pkg::OFS_INFO1_B, 8'h05, 8'h05);
		// history has slid clean, so nothing new is latched
		repeat (6) fbit(1'b0);
		poll(tris_pkg::OFS_INFO1_B, 8'h05, 8'h00);
		fbit(1'b1);
		poll(tris_pkg::OFS_INFO1_B, 8'h05, 8'h01);
		fb.alignment_changed = 1'b1;
		wait_n(1);
		fb.alignment_changed = 1'b0;
		poll(tris_pkg::OFS_INFO1_B, 8'h80, 8'h80);
		$display("framing test done");
	endtask : t_framing

	task automatic t_code();
		poll(tris_pkg::OFS_INFO1_B, 8'h02, 8'h00);
		cw = 1'b1;
		wait_n(8);
		cw = 1'b0;
		poll(tris_pkg::OFS_INFO1_B, 8'h02, 8'h02);
		$display("code word test done");
	endtask : t_code

	initial begin
		fb.bit_valid = 1'b1;
		wait_n(2);
		rst = 1'b0;
		t_reset();
		t_zero();
		t_line();
		t_clock();
		t_level_ais();
		t_latch(1'b0);
		t_latch(1'b1);
		t_framing();
		t_code();
		test_done();
	end

	initial begin
		#100000;
		num_errors++;
		$display("BAD watchdog exp done got hung");
		test_done();
	end
endmodule : tris_info_test
